// File: hdl/ntc_top.sv
// Interrupt controller with exception sequencer and tick timer
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module ntc_top (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                nrst,
  // Register port
  input  wire logic [31:0]         bus_addr,
  input  wire logic [31:0]         bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic [31:0]              bus_rdata,
  // Peripheral request lines
  input  wire logic                brownout_irq,
  input  wire logic                watchdog_irq,
  input  wire logic                ext_pin_irq_a,
  input  wire logic                ext_pin_irq_b,
  input  wire logic                port_group_low_irq,
  input  wire logic                port_group_high_irq,
  input  wire logic                pulse_group_low_irq,
  input  wire logic                pulse_group_high_irq,
  input  wire logic                timer_zero_irq,
  input  wire logic                timer_one_irq,
  input  wire logic [31:10]        other_irq,
  input  wire logic                nmi_req,
  // Core exception signals
  input  wire logic                hardfault_req,
  input  wire logic                svc_req,
  input  wire logic                exc_return,
  input  wire ntc_pkg::ntc_frame_t core_frame,
  output ntc_pkg::ntc_frame_t      frame_out,
  output logic                     frame_load,
  output logic [31:0]              pc_value,
  output logic                     pc_load,
  output logic [31:0]              sp_value,
  output logic                     handler_mode,
  output logic [5:0]               exc_num,
  output logic                     core_hold,
  // Memory master
  output ntc_pkg::ntc_mem_t        mem_out,
  input  wire logic                mem_ack,
  input  wire logic [31:0]         mem_rdata
);

  // Reset release
  logic rs1_r;
  logic rs2_r;
  logic rst_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign rst_n = rs2_r;

  // Most urgent member of a mask, lowest vector on a tie
  function automatic logic [8:0] ntc_best(input logic [47:0] m,
                                          input logic [47:0][2:0] rk);
    logic [2:0] br;
    logic [5:0] bv;
    br = ntc_pkg::RANK_NONE;
    bv = 6'h00;
    for (int i = 0; i < ntc_pkg::NUM_VEC; i++) begin
      if (m[i] && (rk[i] < br)) begin
        br = rk[i];
        bv = 6'(i);
      end
    end
    return {br, bv};
  endfunction : ntc_best

  function automatic logic [2:0] ntc_cfg_rank(input logic [1:0] pri);
    return ntc_pkg::RANK_CFG0 + {1'b0, pri};
  endfunction : ntc_cfg_rank

  // State
  ntc_pkg::ntc_state_t state_r, state_nxt;
  logic [2:0]          cnt_r, cnt_nxt;
  logic [5:0]          sel_vec_r, sel_vec_nxt;
  logic [2:0]          sel_rank_r, sel_rank_nxt;
  logic [31:0]         sp_r, sp_nxt;
  ntc_pkg::ntc_frame_t frame_r, frame_nxt;
  ntc_pkg::ntc_mem_t   mem_r, mem_nxt;
  logic [31:0]         pc_r, pc_nxt;
  logic                pc_load_r, pc_load_nxt;
  logic                frame_load_r, frame_load_nxt;
  logic                handler_r, handler_nxt;
  logic [5:0]          exc_num_r, exc_num_nxt;
  logic                hold_r;
  logic [47:0]         pend_r, pend_nxt;
  logic [47:0]         active_r, active_nxt;
  logic                take;
  logic                exit_req;
  logic                nmi_d_r;
  logic [31:0]         rdata_r;
  logic [31:0]         rd_mux;
  // Configuration
  logic                en_r, en_nxt;
  logic                tickint_r, tickint_nxt;
  logic [23:0]         reload_r, reload_nxt;
  logic [23:0]         cvr_r, cvr_nxt;
  logic                flag_r, flag_nxt;
  logic [31:0]         irq_en_r, irq_en_nxt;
  logic [31:0][1:0]    irq_pri_r, irq_pri_nxt;
  logic [1:0]          svc_pri_r, svc_pri_nxt;
  logic [1:0]          psv_pri_r, psv_pri_nxt;
  logic [1:0]          tick_pri_r, tick_pri_nxt;
  logic [47:0][2:0]    rank;
  logic [47:0]         hw_set;
  logic [47:0]         hw_clr;

  // Address decode
  wire logic hit_csr   = (bus_addr == ntc_pkg::TICK_CSR_ADDR);
  wire logic hit_rvr   = (bus_addr == ntc_pkg::TICK_RVR_ADDR);
  wire logic hit_cvr   = (bus_addr == ntc_pkg::TICK_CVR_ADDR);
  wire logic hit_iser  = (bus_addr == ntc_pkg::ISER_ADDR);
  wire logic hit_icer  = (bus_addr == ntc_pkg::ICER_ADDR);
  wire logic hit_ispr  = (bus_addr == ntc_pkg::ISPR_ADDR);
  wire logic hit_icpr  = (bus_addr == ntc_pkg::ICPR_ADDR);
  wire logic hit_ipr   = (bus_addr[31:5] == ntc_pkg::IPR_ADDR[31:5]);
  wire logic hit_icsr  = (bus_addr == ntc_pkg::ICSR_ADDR);
  wire logic hit_shpr2 = (bus_addr == ntc_pkg::SHPR2_ADDR);
  wire logic hit_shpr3 = (bus_addr == ntc_pkg::SHPR3_ADDR);
  wire logic [2:0] ipr_idx = bus_addr[4:2];

  // Write and read side effects
  wire logic        cvr_wr   = bus_wr && hit_cvr;
  wire logic        csr_rd   = bus_rd && hit_csr;
  wire logic [31:0] ispr_set = (bus_wr && hit_ispr) ? bus_wdata : 32'h0;
  wire logic [31:0] icpr_clr = (bus_wr && hit_icpr) ? bus_wdata : 32'h0;
  wire logic psv_set  = bus_wr && hit_icsr && bus_wdata[ntc_pkg::ICSR_PSV_SET];
  wire logic psv_clr  = bus_wr && hit_icsr && bus_wdata[ntc_pkg::ICSR_PSV_CLR];
  wire logic tick_set = bus_wr && hit_icsr && bus_wdata[ntc_pkg::ICSR_TICK_SET];
  wire logic tick_clr = bus_wr && hit_icsr && bus_wdata[ntc_pkg::ICSR_TICK_CLR];

  // Peripheral line assembly
  wire logic [31:0] irq_in = {other_irq,
                              timer_one_irq, timer_zero_irq,
                              pulse_group_high_irq, pulse_group_low_irq,
                              port_group_high_irq, port_group_low_irq,
                              ext_pin_irq_b, ext_pin_irq_a,
                              watchdog_irq, brownout_irq};
  wire logic nmi_rise = nmi_req && !nmi_d_r;

  // Tick timer
  wire logic tick_zero_step = en_r && !cvr_wr && (cvr_r == 24'h00_0001);
  wire logic tick_pend_evt  = tick_zero_step && tickint_r;

  always_comb begin
    cvr_nxt = cvr_r;
    if (cvr_wr) begin
      cvr_nxt = 24'h00_0000;
    end else if (en_r) begin
      if (cvr_r == 24'h00_0000) begin
        cvr_nxt = reload_r;
      end else begin
        cvr_nxt = cvr_r - 24'h00_0001;
      end
    end
  end
  assign flag_nxt = tick_zero_step || (flag_r && !csr_rd && !cvr_wr);

  // Urgency ranks per vector
  always_comb begin
    rank = {ntc_pkg::NUM_VEC{ntc_pkg::RANK_NONE}};
    rank[ntc_pkg::VEC_NMI]  = ntc_pkg::RANK_NMI;
    rank[ntc_pkg::VEC_HARD] = ntc_pkg::RANK_HARD;
    rank[ntc_pkg::VEC_SVC]  = ntc_cfg_rank(svc_pri_r);
    rank[ntc_pkg::VEC_PSV]  = ntc_cfg_rank(psv_pri_r);
    rank[ntc_pkg::VEC_TICK] = ntc_cfg_rank(tick_pri_r);
    for (int i = 0; i < ntc_pkg::NUM_IRQ; i++) begin
      rank[ntc_pkg::VEC_IRQ0 + i] = ntc_cfg_rank(irq_pri_r[i]);
    end
  end

  // Selection
  wire logic [47:0] elig = pend_r & {irq_en_r, ntc_pkg::SYS_VEC_MASK};
  wire logic [8:0]  best_p = ntc_best(elig, rank);
  wire logic [8:0]  best_a = ntc_best(active_r, rank);
  wire logic [2:0]  pr = best_p[8:6];
  wire logic [5:0]  pv = best_p[5:0];
  wire logic [2:0]  ar = best_a[8:6];
  wire logic [5:0]  av = best_a[5:0];
  wire logic [8:0]  best_r = ntc_best(active_r & ~(48'h1 << av), rank);
  wire logic [2:0]  rr = best_r[8:6];
  wire logic [31:0] stack_addr = sp_r - ntc_pkg::FRAME_BYTES + {27'h0, cnt_r, 2'b00};
  wire logic [31:0] vec_addr = ntc_pkg::VT_BASE + {24'h0, sel_vec_r, 2'b00};

  // Exception sequencer
  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    sel_vec_nxt    = sel_vec_r;
    sel_rank_nxt   = sel_rank_r;
    sp_nxt         = sp_r;
    frame_nxt      = frame_r;
    mem_nxt        = mem_r;
    pc_nxt         = pc_r;
    pc_load_nxt    = 1'b0;
    frame_load_nxt = 1'b0;
    handler_nxt    = handler_r;
    exc_num_nxt    = exc_num_r;
    take           = 1'b0;
    exit_req       = 1'b0;
    case (state_r)
      ntc_pkg::ST_BOOT_SP: begin
        if (!mem_r.req) begin
          mem_nxt = '{req: 1'b1, we: 1'b0, addr: ntc_pkg::VT_BASE, wdata: 32'h0};
        end else if (mem_ack) begin
          mem_nxt.req = 1'b0;
          sp_nxt      = mem_rdata;
          state_nxt   = ntc_pkg::ST_BOOT_PC;
        end
      end
      ntc_pkg::ST_BOOT_PC: begin
        if (!mem_r.req) begin
          mem_nxt = '{req: 1'b1, we: 1'b0, wdata: 32'h0,
                      addr: ntc_pkg::VT_BASE + 32'(4 * ntc_pkg::VEC_RESET)};
        end else if (mem_ack) begin
          mem_nxt.req = 1'b0;
          pc_nxt      = mem_rdata;
          pc_load_nxt = 1'b1;
          state_nxt   = ntc_pkg::ST_RUN;
        end
      end
      ntc_pkg::ST_RUN: begin
        if (exc_return && handler_r) begin
          exit_req = 1'b1;
          if (pr < rr) begin
            sel_vec_nxt  = pv;
            sel_rank_nxt = pr;
            state_nxt    = ntc_pkg::ST_FETCH;
          end else begin
            cnt_nxt   = 3'h0;
            state_nxt = ntc_pkg::ST_UNSTACK;
          end
        end else if (pr < ar) begin
          sel_vec_nxt  = pv;
          sel_rank_nxt = pr;
          cnt_nxt      = 3'h0;
          state_nxt    = ntc_pkg::ST_STACK;
        end
      end
      ntc_pkg::ST_STACK: begin
        if (pr < sel_rank_r) begin
          sel_vec_nxt  = pv;
          sel_rank_nxt = pr;
        end
        if (!mem_r.req) begin
          mem_nxt = '{req: 1'b1, we: 1'b1, addr: stack_addr, wdata: core_frame[cnt_r]};
        end else if (mem_ack) begin
          mem_nxt.req = 1'b0;
          cnt_nxt     = cnt_r + 3'h1;
          if (cnt_r == 3'(ntc_pkg::FRAME_WORDS - 1)) begin
            sp_nxt    = sp_r - ntc_pkg::FRAME_BYTES;
            state_nxt = ntc_pkg::ST_FETCH;
          end
        end
      end
      ntc_pkg::ST_FETCH: begin
        if (!mem_r.req) begin
          mem_nxt = '{req: 1'b1, we: 1'b0, addr: vec_addr, wdata: 32'h0};
        end else if (mem_ack) begin
          mem_nxt.req = 1'b0;
          if (pr < sel_rank_r) begin
            sel_vec_nxt  = pv;
            sel_rank_nxt = pr;
          end else begin
            take        = 1'b1;
            pc_nxt      = mem_rdata;
            pc_load_nxt = 1'b1;
            handler_nxt = 1'b1;
            exc_num_nxt = sel_vec_r;
            state_nxt   = ntc_pkg::ST_RUN;
          end
        end
      end
      ntc_pkg::ST_UNSTACK: begin
        if (!mem_r.req) begin
          mem_nxt = '{req: 1'b1, we: 1'b0, wdata: 32'h0,
                      addr: sp_r + {27'h0, cnt_r, 2'b00}};
        end else if (mem_ack) begin
          mem_nxt.req      = 1'b0;
          frame_nxt[cnt_r] = mem_rdata;
          cnt_nxt          = cnt_r + 3'h1;
          if (cnt_r == 3'(ntc_pkg::FRAME_WORDS - 1)) begin
            sp_nxt         = sp_r + ntc_pkg::FRAME_BYTES;
            frame_load_nxt = 1'b1;
            handler_nxt    = (ar != ntc_pkg::RANK_NONE);
            exc_num_nxt    = (ar != ntc_pkg::RANK_NONE) ? av : 6'h00;
            state_nxt      = ntc_pkg::ST_RUN;
          end
        end
      end
      default: begin
        state_nxt = ntc_pkg::ST_BOOT_SP;
      end
    endcase
  end

  // Pending and active bookkeeping, hardware set wins over clear
  always_comb begin
    hw_set = 48'h0;
    hw_clr = 48'h0;
    hw_set[ntc_pkg::VEC_NMI]  = nmi_rise;
    hw_set[ntc_pkg::VEC_HARD] = hardfault_req;
    hw_set[ntc_pkg::VEC_SVC]  = svc_req;
    hw_set[ntc_pkg::VEC_PSV]  = psv_set;
    hw_set[ntc_pkg::VEC_TICK] = tick_pend_evt || tick_set;
    hw_set[47:16]             = irq_in | ispr_set;
    hw_clr[ntc_pkg::VEC_PSV]  = psv_clr;
    hw_clr[ntc_pkg::VEC_TICK] = tick_clr;
    hw_clr[47:16]             = icpr_clr;
    if (take) begin
      hw_clr[sel_vec_r] = 1'b1;
    end
    pend_nxt   = (pend_r & ~hw_clr) | hw_set;
    active_nxt = active_r;
    if (exit_req) begin
      active_nxt[av] = 1'b0;
    end
    if (take) begin
      active_nxt[sel_vec_r] = 1'b1;
    end
  end

  // Register writes
  always_comb begin
    en_nxt       = en_r;
    tickint_nxt  = tickint_r;
    reload_nxt   = reload_r;
    irq_en_nxt   = irq_en_r;
    irq_pri_nxt  = irq_pri_r;
    svc_pri_nxt  = svc_pri_r;
    psv_pri_nxt  = psv_pri_r;
    tick_pri_nxt = tick_pri_r;
    if (bus_wr) begin
      if (hit_csr) begin
        en_nxt      = bus_wdata[ntc_pkg::CSR_EN_BIT];
        tickint_nxt = bus_wdata[ntc_pkg::CSR_INT_BIT];
      end
      if (hit_rvr) begin
        reload_nxt = bus_wdata[ntc_pkg::TICK_W-1:0];
      end
      if (hit_iser) begin
        irq_en_nxt = irq_en_r | bus_wdata;
      end
      if (hit_icer) begin
        irq_en_nxt = irq_en_r & ~bus_wdata;
      end
      if (hit_ipr) begin
        for (int b = 0; b < 4; b++) begin
          irq_pri_nxt[{ipr_idx, 2'(b)}] = bus_wdata[8*b+ntc_pkg::IPR_FIELD_LSB +: 2];
        end
      end
      if (hit_shpr2) begin
        svc_pri_nxt = bus_wdata[ntc_pkg::SHPR2_SVC_LSB +: 2];
      end
      if (hit_shpr3) begin
        psv_pri_nxt  = bus_wdata[ntc_pkg::SHPR3_PSV_LSB +: 2];
        tick_pri_nxt = bus_wdata[ntc_pkg::SHPR3_TICK_LSB +: 2];
      end
    end
  end

  // Register reads
  always_comb begin
    rd_mux = 32'h0;
    if (hit_csr) begin
      rd_mux[ntc_pkg::CSR_EN_BIT]   = en_r;
      rd_mux[ntc_pkg::CSR_INT_BIT]  = tickint_r;
      rd_mux[ntc_pkg::CSR_FLAG_BIT] = flag_r;
    end
    if (hit_rvr) begin
      rd_mux = {8'h00, reload_r};
    end
    if (hit_cvr) begin
      rd_mux = {8'h00, cvr_r};
    end
    if (hit_iser || hit_icer) begin
      rd_mux = irq_en_r;
    end
    if (hit_ispr || hit_icpr) begin
      rd_mux = pend_r[47:16];
    end
    if (hit_ipr) begin
      for (int b = 0; b < 4; b++) begin
        rd_mux[8*b+ntc_pkg::IPR_FIELD_LSB +: 2] = irq_pri_r[{ipr_idx, 2'(b)}];
      end
    end
    if (hit_icsr) begin
      rd_mux[5:0]                               = exc_num_r;
      rd_mux[ntc_pkg::ICSR_PVEC_LSB +: 6]       = pv;
      rd_mux[ntc_pkg::ICSR_NMI_PEND]            = pend_r[ntc_pkg::VEC_NMI];
      rd_mux[ntc_pkg::ICSR_PSV_SET]             = pend_r[ntc_pkg::VEC_PSV];
      rd_mux[ntc_pkg::ICSR_TICK_SET]            = pend_r[ntc_pkg::VEC_TICK];
    end
    if (hit_shpr2) begin
      rd_mux[ntc_pkg::SHPR2_SVC_LSB +: 2] = svc_pri_r;
    end
    if (hit_shpr3) begin
      rd_mux[ntc_pkg::SHPR3_PSV_LSB +: 2]  = psv_pri_r;
      rd_mux[ntc_pkg::SHPR3_TICK_LSB +: 2] = tick_pri_r;
    end
  end

  // Sequencer flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ntc_pkg::ST_BOOT_SP;
      cnt_r        <= 3'h0;
      sel_vec_r    <= 6'h00;
      sel_rank_r   <= ntc_pkg::RANK_NONE;
      sp_r         <= 32'h0000_0000;
      frame_r      <= '0;
      mem_r        <= '0;
      pc_r         <= 32'h0000_0000;
      pc_load_r    <= 1'b0;
      frame_load_r <= 1'b0;
      handler_r    <= 1'b0;
      exc_num_r    <= 6'h00;
      hold_r       <= 1'b1;
      pend_r       <= 48'h0;
      active_r     <= 48'h0;
      nmi_d_r      <= 1'b0;
      rdata_r      <= 32'h0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      sel_vec_r    <= sel_vec_nxt;
      sel_rank_r   <= sel_rank_nxt;
      sp_r         <= sp_nxt;
      frame_r      <= frame_nxt;
      mem_r        <= mem_nxt;
      pc_r         <= pc_nxt;
      pc_load_r    <= pc_load_nxt;
      frame_load_r <= frame_load_nxt;
      handler_r    <= handler_nxt;
      exc_num_r    <= exc_num_nxt;
      hold_r       <= (state_nxt != ntc_pkg::ST_RUN);
      pend_r       <= pend_nxt;
      active_r     <= active_nxt;
      nmi_d_r      <= nmi_req;
      rdata_r      <= bus_rd ? rd_mux : 32'h0;
    end
  end

  // Configuration and tick flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_r       <= 1'b0;
      tickint_r  <= 1'b0;
      reload_r   <= 24'h00_0000;
      cvr_r      <= 24'h00_0000;
      flag_r     <= 1'b0;
      irq_en_r   <= 32'h0;
      irq_pri_r  <= {ntc_pkg::NUM_IRQ{ntc_pkg::PRI_RESET}};
      svc_pri_r  <= ntc_pkg::PRI_RESET;
      psv_pri_r  <= ntc_pkg::PRI_RESET;
      tick_pri_r <= ntc_pkg::PRI_RESET;
    end else begin
      en_r       <= en_nxt;
      tickint_r  <= tickint_nxt;
      reload_r   <= reload_nxt;
      cvr_r      <= cvr_nxt;
      flag_r     <= flag_nxt;
      irq_en_r   <= irq_en_nxt;
      irq_pri_r  <= irq_pri_nxt;
      svc_pri_r  <= svc_pri_nxt;
      psv_pri_r  <= psv_pri_nxt;
      tick_pri_r <= tick_pri_nxt;
    end
  end

  // Outputs
  assign bus_rdata    = rdata_r;
  assign frame_out    = frame_r;
  assign frame_load   = frame_load_r;
  assign pc_value     = pc_r;
  assign pc_load      = pc_load_r;
  assign sp_value     = sp_r;
  assign handler_mode = handler_r;
  assign exc_num      = exc_num_r;
  assign core_hold    = hold_r;
  assign mem_out      = mem_r;

endmodule : ntc_top

// File: inc/ntc_pkg.sv
// Constants, types and register map for the interrupt controller with tick timer
package ntc_pkg;

  // Register addresses
  localparam logic [31:0] TICK_CSR_ADDR = 32'hE000_E010;
  localparam logic [31:0] TICK_RVR_ADDR = 32'hE000_E014;
  localparam logic [31:0] TICK_CVR_ADDR = 32'hE000_E018;
  localparam logic [31:0] ISER_ADDR     = 32'hE000_E100;
  localparam logic [31:0] ICER_ADDR     = 32'hE000_E180;
  localparam logic [31:0] ISPR_ADDR     = 32'hE000_E200;
  localparam logic [31:0] ICPR_ADDR     = 32'hE000_E280;
  localparam logic [31:0] IPR_ADDR      = 32'hE000_E400;
  localparam logic [31:0] ICSR_ADDR     = 32'hE000_ED04;
  localparam logic [31:0] SHPR2_ADDR    = 32'hE000_ED1C;
  localparam logic [31:0] SHPR3_ADDR    = 32'hE000_ED20;

  // Field positions
  localparam int CSR_EN_BIT     = 0;
  localparam int CSR_INT_BIT    = 1;
  localparam int CSR_FLAG_BIT   = 16;
  localparam int ICSR_NMI_PEND  = 31;
  localparam int ICSR_PSV_SET   = 28;
  localparam int ICSR_PSV_CLR   = 27;
  localparam int ICSR_TICK_SET  = 26;
  localparam int ICSR_TICK_CLR  = 25;
  localparam int ICSR_PVEC_LSB  = 12;
  localparam int SHPR2_SVC_LSB  = 30;
  localparam int SHPR3_PSV_LSB  = 22;
  localparam int SHPR3_TICK_LSB = 30;
  localparam int IPR_FIELD_LSB  = 6;
  localparam int TICK_W         = 24;

  // Vector numbers and peripheral line numbers
  localparam int VEC_RESET = 1;
  localparam int VEC_NMI   = 2;
  localparam int VEC_HARD  = 3;
  localparam int VEC_SVC   = 11;
  localparam int VEC_PSV   = 14;
  localparam int VEC_TICK  = 15;
  localparam int VEC_IRQ0  = 16;
  localparam int NUM_VEC   = 48;
  localparam int NUM_IRQ   = 32;
  localparam logic [15:0] SYS_VEC_MASK = 16'hC80C;
  localparam int IRQ_BROWNOUT = 0;
  localparam int IRQ_WATCHDOG = 1;
  localparam int IRQ_EXT_A    = 2;
  localparam int IRQ_EXT_B    = 3;
  localparam int IRQ_PORT_LO  = 4;
  localparam int IRQ_PORT_HI  = 5;
  localparam int IRQ_PULSE_LO = 6;
  localparam int IRQ_PULSE_HI = 7;
  localparam int IRQ_TIMER0   = 8;
  localparam int IRQ_TIMER1   = 9;

  // Internal urgency ranks, lower is more urgent
  localparam logic [2:0] RANK_NMI  = 3'h1;
  localparam logic [2:0] RANK_HARD = 3'h2;
  localparam logic [2:0] RANK_CFG0 = 3'h3;
  localparam logic [2:0] RANK_NONE = 3'h7;
  localparam logic [1:0] PRI_RESET = 2'h0;

  // Stack frame and vector table
  localparam int          FRAME_WORDS = 8;
  localparam logic [31:0] FRAME_BYTES = 32'h0000_0020;
  localparam logic [31:0] VT_BASE     = 32'h0000_0000;

  typedef logic [FRAME_WORDS-1:0][31:0] ntc_frame_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ntc_mem_t;

  typedef enum logic [2:0] {
    ST_BOOT_SP, ST_BOOT_PC, ST_RUN, ST_STACK, ST_FETCH, ST_UNSTACK
  } ntc_state_t;

endpackage : ntc_pkg

// File: test/ntc_props.sv
// Port checks for the controller
`timescale 1ns/1ps
module ntc_props (
  // Watched ports
  input wire logic              clock,
  input wire logic              nrst,
  input wire logic              bus_rd,
  input wire logic [31:0]       bus_rdata,
  input wire logic              pc_load,
  input wire logic [31:0]       pc_value,
  input wire logic              handler_mode,
  input wire logic [5:0]        exc_num,
  input wire logic              core_hold,
  input wire ntc_pkg::ntc_mem_t mem_out,
  input wire logic              mem_ack,
  input wire logic [31:0]       mem_rdata,
  input wire logic              frame_load
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_RD_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("stray read data");
  AST_PC_MODE: assert property (pc_load |-> handler_mode == (exc_num != 6'h0))
    else $error("mode mismatch at entry");
  AST_REQ_HOLD: assert property (mem_out.req |-> core_hold)
    else $error("memory request while core runs");
  AST_REQ_KEEP: assert property (mem_out.req && !mem_ack |=> $stable(mem_out))
    else $error("request changed before ack");
  AST_REQ_GAP: assert property (mem_out.req && mem_ack |=> !mem_out.req)
    else $error("no idle after ack");
  AST_VEC_OK: assert property (handler_mode |-> exc_num inside {6'h2, 6'h3, 6'hB, [6'hE:6'h2F]})
    else $error("bad vector");
  AST_PC_FETCH: assert property (pc_load |-> $past(mem_ack) && pc_value == $past(mem_rdata))
    else $error("pc not from table");
  AST_PC_RUN: assert property (pc_load |-> !core_hold ##1 !pc_load)
    else $error("entry pulse wrong");
  cover property (pc_load && handler_mode);
  cover property (frame_load);
  cover property (mem_out.req && !mem_ack);
endmodule : ntc_props

// File: test/ntc_mem_model.sv
// Memory holding vector table and stack
`timescale 1ns/1ps
module ntc_mem_model (
  // Clock and stall control
  input wire logic              clock,
  input wire logic              slow,
  // Memory port
  input wire ntc_pkg::ntc_mem_t mem_out,
  output logic                  mem_ack,
  output logic [31:0]           mem_rdata
);
  logic [31:0] ram [64];
  logic        wait_r;
  initial begin
    {mem_ack, wait_r} = 2'h0;
    mem_rdata = 32'h0;
    ram[0] = 32'h2000_0400;
    for (int v = 1; v < 48; v++) ram[v] = 32'h1000 + v * 16;
  end
  // Stack words fold onto entries 48 to 63
  always @(posedge clock) begin
    wait_r <= mem_out.req && !mem_ack && !wait_r;
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_out.req && !mem_ack && (!slow || wait_r)) begin
      mem_ack <= 1'b1;
      if (mem_out.we) ram[mem_out.addr[7:2]] <= mem_out.wdata;
      else mem_rdata <= ram[mem_out.addr[7:2]];
    end
  end
endmodule : ntc_mem_model

// File: test/ntc_top_tb.sv
// Bench for the controller and tick timer
`timescale 1ns/1ps
module ntc_top_tb;
  logic clock, nrst, bus_wr, bus_rd, nmi_req, exc_return, slow, pc_load, frame_load;
  logic handler_mode, mem_ack, f, hf, svc;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, irq, pc_value, mem_rdata, rd;
  logic [5:0] exc_num;
  ntc_pkg::ntc_frame_t core_frame, frame_out;
  ntc_pkg::ntc_mem_t mem_out;
  int errors, check_count;
  ntc_top ntc_top_i (.clock, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .brownout_irq(irq[0]), .watchdog_irq(irq[1]), .ext_pin_irq_a(irq[2]),
    .ext_pin_irq_b(irq[3]), .port_group_low_irq(irq[4]), .port_group_high_irq(irq[5]),
    .pulse_group_low_irq(irq[6]), .pulse_group_high_irq(irq[7]), .timer_zero_irq(irq[8]),
    .timer_one_irq(irq[9]), .other_irq(irq[31:10]), .nmi_req, .hardfault_req(hf),
    .svc_req(svc), .exc_return, .core_frame, .frame_out, .frame_load, .pc_value, .pc_load,
    .sp_value(), .handler_mode, .exc_num, .core_hold(), .mem_out, .mem_ack, .mem_rdata);
  ntc_mem_model ntc_mem_model_i (.clock, .slow, .mem_out, .mem_ack, .mem_rdata);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic finish_test();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_wr <= w;
    bus_rd <= !w;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clock);
    {bus_wr, bus_rd} <= 2'h0;
    @(negedge clock);
    rd = bus_rdata;
  endtask : bus
  task automatic drive(input logic [31:0] m, input logic n, input logic x);
    @(posedge clock);
    irq <= m;
    nmi_req <= n;
    exc_return <= x;
    @(posedge clock);
    {irq, nmi_req, exc_return} <= 34'h0;
  endtask : drive
  task automatic wait_ev(input logic pc);
    f = 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clock);
      f |= frame_load;
      if ((pc ? pc_load : frame_load) === 1'b1) return;
    end
    errors++;
    finish_test();
  endtask : wait_ev
  task automatic entry(input logic [5:0] v);
    wait_ev(1'b1);
    cmp(exc_num, v);
    cmp(pc_value, 32'h1000 + v * 16);
    cmp(handler_mode, 32'h1);
  endtask : entry
  task automatic scn_lines();
    drive(32'hFFFF_FFFF, 1'b0, 1'b0);
    bus(1'b0, ntc_pkg::ISPR_ADDR, 32'h0);
    cmp(rd, 32'hFFFF_FFFF);
    bus(1'b1, ntc_pkg::ICPR_ADDR, 32'hFFFF_FFFF);
    bus(1'b0, ntc_pkg::ISPR_ADDR, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b0, ntc_pkg::IPR_ADDR, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b0, 32'hE000_E00C, 32'h0);
    cmp(rd, 32'h0);
  endtask : scn_lines
  task automatic scn_tick();
    logic [31:0] v;
    bus(1'b1, ntc_pkg::TICK_RVR_ADDR, 32'hFF);
    bus(1'b1, ntc_pkg::TICK_CVR_ADDR, 32'h0);
    bus(1'b1, ntc_pkg::TICK_CSR_ADDR, 32'h1);
    repeat (300) @(posedge clock);
    bus(1'b0, ntc_pkg::TICK_CSR_ADDR, 32'h0);
    cmp(rd[16], 32'h1);
    bus(1'b0, ntc_pkg::TICK_CSR_ADDR, 32'h0);
    cmp(rd[16], 32'h0);
    bus(1'b0, ntc_pkg::TICK_CVR_ADDR, 32'h0);
    v = rd;
    bus(1'b0, ntc_pkg::TICK_CVR_ADDR, 32'h0);
    cmp(rd, v > 1 ? v - 2 : v + 32'hFE);
    bus(1'b1, ntc_pkg::TICK_RVR_ADDR, 32'h0);
    repeat (300) @(posedge clock);
    bus(1'b0, ntc_pkg::TICK_CVR_ADDR, 32'h0);
    cmp(rd, 32'h0);
  endtask : scn_tick
  task automatic scn_nest();
    bus(1'b1, ntc_pkg::ISER_ADDR, 32'h102);
    drive(32'h102, 1'b0, 1'b0);
    entry(6'h11);
    slow <= 1'b1;
    drive(32'h0, 1'b1, 1'b0);
    entry(6'h2);
    drive(32'h0, 1'b0, 1'b1);
    wait_ev(1'b0);
    @(negedge clock);
    cmp(exc_num, 32'h11);
    drive(32'h0, 1'b0, 1'b1);
    entry(6'h18);
    cmp(f, 32'h0);
    drive(32'h0, 1'b0, 1'b1);
    wait_ev(1'b0);
    for (int i = 0; i < 8; i++) cmp(frame_out[i], core_frame[i]);
    @(negedge clock);
    cmp(handler_mode, 32'h0);
  endtask : scn_nest
  task automatic scn_late();
    bus(1'b1, ntc_pkg::ISER_ADDR, 32'h200);
    bus(1'b1, ntc_pkg::ISPR_ADDR, 32'h200);
    @(posedge clock);
    {hf, svc} <= 2'h3;
    @(posedge clock);
    {hf, svc} <= 2'h0;
    entry(6'h3);
    drive(32'h0, 1'b0, 1'b1);
    entry(6'hB);
    drive(32'h0, 1'b0, 1'b1);
    entry(6'h19);
    bus(1'b1, ntc_pkg::TICK_RVR_ADDR, 32'h20);
    bus(1'b1, ntc_pkg::TICK_CSR_ADDR, 32'h3);
    bus(1'b1, ntc_pkg::TICK_RVR_ADDR, 32'h0);
    repeat (40) @(posedge clock);
    drive(32'h0, 1'b0, 1'b1);
    entry(6'hF);
    cmp(f, 32'h0);
    drive(32'h0, 1'b0, 1'b1);
    wait_ev(1'b0);
    cmp(exc_num, 32'h0);
  endtask : scn_late
  initial begin
    {nrst, bus_wr, bus_rd, nmi_req, exc_return, slow, hf, svc} = 8'h0;
    {bus_addr, bus_wdata, irq} = 96'h0;
    errors = 0;
    check_count = 0;
    for (int i = 0; i < 8; i++) core_frame[i] = 32'hC0DE_0000 + i;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    wait_ev(1'b1);
    cmp(pc_value, 32'h1010);
    scn_lines();
    scn_tick();
    scn_nest();
    scn_late();
    finish_test();
  end
endmodule : ntc_top_tb
bind ntc_top ntc_props ntc_props_i (.clock, .nrst, .bus_rd, .bus_rdata, .pc_load, .pc_value,
  .handler_mode, .exc_num, .core_hold, .mem_out, .mem_ack, .mem_rdata, .frame_load);
